// ==== tsi_interp.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsi_interp #(
    parameter int unsigned SCROLL_GAP = tsi_pkg::SCROLL_GAP_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic [7:0] RX_DATA,
    input  wire logic       RX_VALID,
    output logic            RX_READY,
    output logic      [7:0] TX_DATA,
    output logic            TX_VALID,
    input  wire logic       TX_READY,
    input  wire logic [4:0] CUR_ROW,
    input  wire logic [6:0] CUR_COL,
    input  wire logic [3:0] CUR_ATTR,
    input  wire logic [2:0] CUR_CSET,
    input  wire logic       MARGIN_ORIGIN_MODE,
    output logic            CURSOR_LOAD,
    output logic            LOAD_FULL,
    output logic      [4:0] LOAD_ROW,
    output logic      [6:0] LOAD_COL,
    output logic      [3:0] LOAD_ATTR,
    output logic      [2:0] LOAD_CSET,
    output logic            SMOOTH_SCROLL_MODE,
    output logic            INVERSE_SCREEN_MODE,
    output logic      [4:0] TOP_MARGIN,
    output logic      [4:0] BOTTOM_MARGIN,
    input  wire logic       SCROLL_REQ,
    output logic            SCROLL_GO,
    input  wire logic       NEW_LINE,
    input  wire logic [4:0] NEW_LINE_ROW,
    output logic            WIDTH_RESET,
    output logic      [4:0] WIDTH_FIRST,
    output logic      [4:0] WIDTH_LAST,
    output logic            ERASE_GO,
    output logic      [1:0] ERASE_MODE,
    output logic            TEST_START,
    output logic      [3:0] TEST_SEL,
    output logic            SELF_RESET,
    input  wire logic       MALFUNCTION,
    input  wire logic [1:0] PARITY_SEL,
    input  wire logic       EIGHT_BITS,
    input  wire logic [3:0] TX_SPEED,
    input  wire logic [3:0] RX_SPEED,
    input  wire logic [3:0] PROCESSOR_OPTION_FLAGS,
    input  wire logic       SETUP_EXIT
);
    import tsi_pkg::*;

    typedef enum logic [1:0] {P_GND, P_ESC, P_CSI, P_HASH} tsi_pst_t;
    typedef enum logic [2:0] {G_IDLE, G_ESC, G_BRK, G_NUM, G_SEP, G_FIN} tsi_gst_t;

    function automatic logic [7:0] acc_step(input logic [7:0] a, input logic [7:0] d);
        logic [11:0] t;
        t = {4'h0, a} * 12'd10 + {8'h00, d[3:0]};
        return (t > 12'd255) ? 8'hff : t[7:0];
    endfunction

    function automatic logic [7:0] dec_digit(input logic [7:0] v, input logic [1:0] ph);
        logic [7:0] d;
        d = (ph == 2'd0) ? v / 8'd100 : (ph == 2'd1) ? (v / 8'd10) % 8'd10 : v % 8'd10;
        return d + CH_ZERO;
    endfunction

    logic       rst;
    logic       self_q;
    tsi_pst_t   pst_q;
    tsi_gst_t   gst_q;
    logic [7:0] acc_q;
    logic [7:0] p0_q;
    logic       has_q;
    logic       has0_q;
    logic [1:0] pidx_q;
    logic       priv_q;
    logic       s4_q;
    logic       s5_q;
    logic       rx_ok;
    logic       fin;
    logic       pub;
    logic [7:0] b;
    logic [7:0] f0;
    logic [7:0] f1;
    logic       h0;
    logic       h1;
    logic       m4;
    logic       m5;
    logic [7:0] top;
    logic [7:0] bot;
    logic       a_req;
    logic       a_test;
    logic       a_dsr;
    logic       a_cpr;
    logic       a_ed;
    logic       a_marg;
    logic       a_mode;
    logic       a_save;
    logic       a_rest;
    logic       a_swl;
    logic       a_unsol;
    logic       unsol_q;
    logic       unsol_pend_q;
    logic       smooth_q;
    logic       inv_q;
    logic [4:0] top_q;
    logic [4:0] bot_q;
    logic [4:0] sv_row_q;
    logic [6:0] sv_col_q;
    logic [3:0] sv_attr_q;
    logic [2:0] sv_cset_q;
    logic [24:0] gap_q;
    logic       ed_hit;
    logic [4:0] ed_first;
    logic [4:0] ed_last;
    logic       msg_ld;
    logic [2:0] msg_n;
    logic [7:0] msg_f;
    logic [7:0] mv [7];
    logic [7:0] num_q [7];
    logic [2:0] nn_q;
    logic [2:0] ni_q;
    logic [1:0] dph_q;
    logic [7:0] fin_q;
    logic [7:0] tx_d_q;
    logic       tx_v_q;
    logic       tx_free;
    logic [7:0] cur_num;
    logic       dig_emit;

    // a zero confidence test resets every register except num_q for one cycle
    assign rst      = !RST_N || self_q;
    assign b        = RX_DATA;
    // reception stalls while a reply is built, so replies never overlap
    assign RX_READY = (gst_q == G_IDLE) && !NEW_LINE && !(unsol_pend_q && unsol_q);
    assign rx_ok    = RX_VALID && RX_READY;
    assign fin      = rx_ok && pst_q == P_CSI && b >= FIN_LO && b <= FIN_HI;
    assign pub      = fin && !priv_q;
    assign f0       = (pidx_q == 2'd0) ? acc_q : p0_q;
    assign h0       = (pidx_q == 2'd0) ? has_q : has0_q;
    assign f1       = (pidx_q == 2'd1) ? acc_q : 8'h00;
    assign h1       = (pidx_q == 2'd1) && has_q;
    assign m4       = s4_q || (has_q && acc_q == MODE_SCROLL);
    assign m5       = s5_q || (has_q && acc_q == MODE_SCREEN);
    assign top      = (h0 && f0 != 8'h00) ? f0 : 8'h01;
    assign bot      = (h1 && f1 != 8'h00) ? f1 : ROWS;

    assign a_req  = pub && b == F_PARM && pidx_q == 2'd0 && f0 <= SOL_REQ_ONLY;
    assign a_test = pub && b == F_TEST && pidx_q == 2'd1 && h0 && f0 == TEST_INTRO
                    && f1 <= TEST_MAX;
    assign a_dsr  = pub && b == F_DSR && pidx_q == 2'd0 && f0 == DSR_STATUS;
    assign a_cpr  = pub && b == F_DSR && pidx_q == 2'd0 && f0 == DSR_CURSOR;
    assign a_ed   = pub && b == F_ED && pidx_q == 2'd0 && f0 <= ED_ALL;
    assign a_marg = pub && b == F_MARG && pidx_q <= 2'd1 && top < bot && bot <= ROWS;
    assign a_mode = fin && priv_q && (b == F_SM || b == F_RM);
    assign a_save = rx_ok && pst_q == P_ESC && b == CH_SAVE;
    assign a_rest = rx_ok && pst_q == P_ESC && b == CH_RESTORE;
    assign a_swl  = rx_ok && pst_q == P_HASH && b == CH_SWL;
    assign a_unsol = (gst_q == G_IDLE) && unsol_pend_q && unsol_q;

    // parameters saturate at 255; only the first two are kept, except mode numbers 4 and 5, which are flagged in any position
    always_ff @(posedge CLK) begin
        if (rst) begin
            pst_q  <= P_GND;
            acc_q  <= 8'h00;
            p0_q   <= 8'h00;
            has_q  <= 1'b0;
            has0_q <= 1'b0;
            pidx_q <= 2'd0;
            priv_q <= 1'b0;
            s4_q   <= 1'b0;
            s5_q   <= 1'b0;
        end else if (rx_ok) begin
            if (b == CH_ESC) begin
                pst_q <= P_ESC;
            end else begin
                unique case (pst_q)
                    P_ESC: begin
                        pst_q  <= (b == CH_LBR) ? P_CSI : (b == CH_HASH) ? P_HASH : P_GND;
                        acc_q  <= 8'h00;
                        p0_q   <= 8'h00;
                        has_q  <= 1'b0;
                        has0_q <= 1'b0;
                        pidx_q <= 2'd0;
                        priv_q <= 1'b0;
                        s4_q   <= 1'b0;
                        s5_q   <= 1'b0;
                    end
                    P_CSI: begin
                        if (b >= CH_ZERO && b <= CH_NINE) begin
                            acc_q <= acc_step(acc_q, b);
                            has_q <= 1'b1;
                        end else if (b == CH_SEMI) begin
                            if (pidx_q == 2'd0) begin
                                p0_q   <= acc_q;
                                has0_q <= has_q;
                            end
                            pidx_q <= (pidx_q == 2'd3) ? 2'd3 : pidx_q + 2'd1;
                            acc_q  <= 8'h00;
                            has_q  <= 1'b0;
                            s4_q   <= m4;
                            s5_q   <= m5;
                        end else if (b == CH_QM && pidx_q == 2'd0 && !has_q) begin
                            priv_q <= 1'b1;
                        end else begin
                            pst_q <= P_GND;
                        end
                    end
                    default: pst_q <= P_GND;
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            smooth_q <= 1'b0;
            inv_q    <= 1'b0;
        end else if (a_mode) begin
            if (m4) smooth_q <= (b == F_SM);
            if (m5) inv_q <= (b == F_SM);
        end
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            top_q <= 5'd1;
            bot_q <= ROWS[4:0];
        end else if (a_marg) begin
            top_q <= top[4:0];
            bot_q <= bot[4:0];
        end
    end

    // an unsolicited report waits for the generator to go idle
    always_ff @(posedge CLK) begin
        if (rst) begin
            unsol_q      <= 1'b0;
            unsol_pend_q <= 1'b0;
        end else begin
            if (a_req) unsol_q <= (f0 == SOL_REQ_ANY);
            if (SETUP_EXIT && unsol_q) unsol_pend_q <= 1'b1;
            else if (a_unsol) unsol_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            sv_row_q  <= 5'd1;
            sv_col_q  <= 7'd1;
            sv_attr_q <= 4'h0;
            sv_cset_q <= 3'h0;
        end else if (a_save) begin
            sv_row_q  <= CUR_ROW;
            sv_col_q  <= CUR_COL;
            sv_attr_q <= CUR_ATTR;
            sv_cset_q <= CUR_CSET;
        end
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            CURSOR_LOAD <= 1'b0;
            LOAD_FULL   <= 1'b0;
            LOAD_ROW    <= 5'd1;
            LOAD_COL    <= 7'd1;
            LOAD_ATTR   <= 4'h0;
            LOAD_CSET   <= 3'h0;
        end else begin
            CURSOR_LOAD <= a_rest || a_marg;
            LOAD_FULL   <= a_rest;
            if (a_rest) begin
                LOAD_ROW  <= sv_row_q;
                LOAD_COL  <= sv_col_q;
                LOAD_ATTR <= sv_attr_q;
                LOAD_CSET <= sv_cset_q;
            end else if (a_marg) begin
                LOAD_ROW <= MARGIN_ORIGIN_MODE ? top[4:0] : 5'd1;
                LOAD_COL <= 7'd1;
            end
        end
    end

    // lines wholly inside the erased range; the cursor line always counts for ED_ALL,
    // otherwise only when the cursor sits in column 1 for ED_BELOW or in column COLS for ED_ABOVE
    always_comb begin
        ed_first = 5'd1;
        ed_last  = ROWS[4:0];
        if (f0 == ED_BELOW) begin
            ed_first = (CUR_COL == 7'd1) ? CUR_ROW : 5'(CUR_ROW + 5'd1);
        end else if (f0 == ED_ABOVE) begin
            ed_last = (CUR_COL == COLS) ? CUR_ROW : 5'(CUR_ROW - 5'd1);
        end
        ed_hit = a_ed && ed_first <= ed_last && ed_last != 5'd0;
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            WIDTH_RESET <= 1'b0;
            WIDTH_FIRST <= 5'd1;
            WIDTH_LAST  <= 5'd1;
            ERASE_GO    <= 1'b0;
            ERASE_MODE  <= 2'd0;
        end else begin
            WIDTH_RESET <= a_swl || NEW_LINE || ed_hit;
            ERASE_GO    <= a_ed;
            if (a_ed) ERASE_MODE <= f0[1:0];
            if (NEW_LINE) begin
                WIDTH_FIRST <= NEW_LINE_ROW;
                WIDTH_LAST  <= NEW_LINE_ROW;
            end else if (a_swl) begin
                WIDTH_FIRST <= CUR_ROW;
                WIDTH_LAST  <= CUR_ROW;
            end else if (ed_hit) begin
                WIDTH_FIRST <= ed_first;
                WIDTH_LAST  <= ed_last;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (rst) begin
            TEST_START <= 1'b0;
            TEST_SEL   <= 4'h0;
            self_q     <= 1'b0;
        end else begin
            TEST_START <= a_test && f1 != 8'h00;
            self_q     <= a_test && f1 == 8'h00;
            if (a_test && f1 != 8'h00) TEST_SEL <= f1[3:0];
        end
    end

    // the gap counter is only consulted in smooth mode
    assign SCROLL_GO = SCROLL_REQ && (!smooth_q || gap_q == 25'd0);
    always_ff @(posedge CLK) begin
        if (rst) gap_q <= 25'd0;
        else if (SCROLL_GO && smooth_q) gap_q <= 25'(SCROLL_GAP - 1);
        else if (gap_q != 25'd0) gap_q <= gap_q - 25'd1;
    end

    always_comb begin
        msg_ld = a_req || a_unsol || a_dsr || a_cpr;
        msg_n  = 3'd1;
        msg_f  = F_DSR;
        for (int i = 0; i < 7; i++) mv[i] = 8'h00;
        if (a_req || a_unsol) begin
            msg_n = 3'd7;
            msg_f = F_PARM;
            mv[0] = (a_req && f0 == SOL_REQ_ONLY) ? SOL_REP_ONLY : SOL_REP;
            mv[1] = (PARITY_SEL == 2'd1) ? PAR_ODD : (PARITY_SEL == 2'd2) ? PAR_EVEN : PAR_NONE;
            mv[2] = EIGHT_BITS ? NBITS_8 : NBITS_7;
            mv[3] = {1'b0, TX_SPEED, 3'b000};
            mv[4] = {1'b0, RX_SPEED, 3'b000};
            mv[5] = CLKMUL_X16;
            mv[6] = {4'h0, PROCESSOR_OPTION_FLAGS};
        end else if (a_dsr) begin
            mv[0] = MALFUNCTION ? DSR_BAD : DSR_OK;
        end else if (a_cpr) begin
            msg_n = 3'd2;
            msg_f = F_CPR;
            mv[0] = {3'h0, CUR_ROW};
            mv[1] = {1'b0, CUR_COL};
        end
    end

    always_ff @(posedge CLK) begin
        if (msg_ld) num_q <= mv;
    end

    assign tx_free  = !tx_v_q || TX_READY;
    assign cur_num  = num_q[ni_q];
    // leading zeros are suppressed; a skipped digit still costs a cycle
    assign dig_emit = dph_q == 2'd2 || (dph_q == 2'd1 && cur_num >= 8'd10) || cur_num >= 8'd100;

    always_ff @(posedge CLK) begin
        if (rst) begin
            gst_q  <= G_IDLE;
            nn_q   <= 3'd1;
            ni_q   <= 3'd0;
            dph_q  <= 2'd0;
            fin_q  <= F_DSR;
            tx_d_q <= 8'h00;
            tx_v_q <= 1'b0;
        end else begin
            if (TX_READY) tx_v_q <= 1'b0;
            if (msg_ld) begin
                nn_q  <= msg_n;
                fin_q <= msg_f;
                ni_q  <= 3'd0;
                dph_q <= 2'd0;
                gst_q <= G_ESC;
            end else if (gst_q != G_IDLE && tx_free) begin
                unique case (gst_q)
                    G_ESC: begin
                        tx_d_q <= CH_ESC;
                        tx_v_q <= 1'b1;
                        gst_q  <= G_BRK;
                    end
                    G_BRK: begin
                        tx_d_q <= CH_LBR;
                        tx_v_q <= 1'b1;
                        gst_q  <= G_NUM;
                    end
                    G_NUM: begin
                        if (dig_emit) begin
                            tx_d_q <= dec_digit(cur_num, dph_q);
                            tx_v_q <= 1'b1;
                        end
                        dph_q <= (dph_q == 2'd2) ? 2'd0 : dph_q + 2'd1;
                        if (dph_q == 2'd2) gst_q <= (ni_q == nn_q - 3'd1) ? G_FIN : G_SEP;
                    end
                    G_SEP: begin
                        tx_d_q <= CH_SEMI;
                        tx_v_q <= 1'b1;
                        ni_q   <= ni_q + 3'd1;
                        gst_q  <= G_NUM;
                    end
                    default: begin
                        tx_d_q <= fin_q;
                        tx_v_q <= 1'b1;
                        gst_q  <= G_IDLE;
                    end
                endcase
            end
        end
    end

    assign TX_DATA             = tx_d_q;
    assign TX_VALID            = tx_v_q;
    assign SMOOTH_SCROLL_MODE  = smooth_q;
    assign INVERSE_SCREEN_MODE = inv_q;
    assign TOP_MARGIN          = top_q;
    assign BOTTOM_MARGIN       = bot_q;
    assign SELF_RESET          = self_q;

    property p_smooth_gap;
        @(posedge CLK) disable iff (rst) SCROLL_GO && smooth_q |=> !SCROLL_GO [*8];
    endproperty
    a_smooth_gap: assert property (p_smooth_gap) else $error("smooth scroll too fast");
    property p_jump;
        @(posedge CLK) disable iff (rst) SCROLL_REQ && !smooth_q |-> SCROLL_GO;
    endproperty
    a_jump: assert property (p_jump) else $error("jump scroll delayed");
    property p_unsol_off;
        @(posedge CLK) disable iff (!RST_N) $rose(RST_N) |-> !unsol_q && !unsol_pend_q;
    endproperty
    a_unsol_off: assert property (p_unsol_off) else $error("unsolicited on after reset");
    property p_region;
        @(posedge CLK) disable iff (rst) TOP_MARGIN < BOTTOM_MARGIN;
    endproperty
    a_region: assert property (p_region) else $error("scroll region under two lines");
    property p_home;
        @(posedge CLK) disable iff (rst) a_marg |=> CURSOR_LOAD && !LOAD_FULL && LOAD_COL == 7'd1;
    endproperty
    a_home: assert property (p_home) else $error("cursor not homed on margins");
    property p_rep_sol;
        @(posedge CLK) disable iff (rst) a_req |=> gst_q == G_ESC && num_q[0] >= SOL_REP;
    endproperty
    a_rep_sol: assert property (p_rep_sol) else $error("bad report code");
    property p_ed_all;
        @(posedge CLK) disable iff (rst)
            a_ed && f0 == ED_ALL |=> !CURSOR_LOAD && WIDTH_RESET && WIDTH_FIRST == 5'd1;
    endproperty
    a_ed_all: assert property (p_ed_all) else $error("full erase wrong");
    property p_self;
        @(posedge CLK) disable iff (!RST_N) a_test && f1 == 8'h00 |=> SELF_RESET && !TEST_START;
    endproperty
    a_self: assert property (p_self) else $error("zero test did not reset");
    property p_tx_hold;
        @(posedge CLK) disable iff (rst) TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped");
endmodule
`default_nettype wire

// ==== tsi_pkg.sv ====
package tsi_pkg;
    localparam logic [7:0] CH_ESC       = 8'h1b;
    localparam logic [7:0] CH_LBR       = 8'h5b;
    localparam logic [7:0] CH_HASH      = 8'h23;
    localparam logic [7:0] CH_QM        = 8'h3f;
    localparam logic [7:0] CH_SEMI      = 8'h3b;
    localparam logic [7:0] CH_ZERO      = 8'h30;
    localparam logic [7:0] CH_NINE      = 8'h39;
    localparam logic [7:0] CH_SAVE      = 8'h37;
    localparam logic [7:0] CH_RESTORE   = 8'h38;
    localparam logic [7:0] CH_SWL       = 8'h35;
    localparam logic [7:0] FIN_LO       = 8'h40;
    localparam logic [7:0] FIN_HI       = 8'h7e;
    localparam logic [7:0] F_PARM       = 8'h78;
    localparam logic [7:0] F_TEST       = 8'h79;
    localparam logic [7:0] F_DSR        = 8'h6e;
    localparam logic [7:0] F_CPR        = 8'h52;
    localparam logic [7:0] F_ED         = 8'h4a;
    localparam logic [7:0] F_MARG       = 8'h72;
    localparam logic [7:0] F_SM         = 8'h68;
    localparam logic [7:0] F_RM         = 8'h6c;
    localparam logic [7:0] SOL_REQ_ANY  = 8'h00;
    localparam logic [7:0] SOL_REQ_ONLY = 8'h01;
    localparam logic [7:0] SOL_REP      = 8'h02;
    localparam logic [7:0] SOL_REP_ONLY = 8'h03;
    localparam logic [7:0] PAR_NONE     = 8'h01;
    localparam logic [7:0] PAR_ODD      = 8'h04;
    localparam logic [7:0] PAR_EVEN     = 8'h05;
    localparam logic [7:0] NBITS_8      = 8'h01;
    localparam logic [7:0] NBITS_7      = 8'h02;
    localparam logic [7:0] CLKMUL_X16   = 8'h01;
    localparam logic [7:0] DSR_OK       = 8'h00;
    localparam logic [7:0] DSR_BAD      = 8'h03;
    localparam logic [7:0] DSR_STATUS   = 8'h05;
    localparam logic [7:0] DSR_CURSOR   = 8'h06;
    localparam logic [7:0] MODE_SCROLL  = 8'h04;
    localparam logic [7:0] MODE_SCREEN  = 8'h05;
    localparam logic [7:0] ED_BELOW     = 8'h00;
    localparam logic [7:0] ED_ABOVE     = 8'h01;
    localparam logic [7:0] ED_ALL       = 8'h02;
    localparam logic [7:0] TEST_INTRO   = 8'h02;
    localparam logic [7:0] TEST_MAX     = 8'h0f;
    localparam logic [7:0] ROWS         = 8'h18;
    localparam logic [6:0] COLS         = 7'h50;
    localparam int unsigned CLK_HZ         = 125000000;
    localparam int unsigned SCROLL_MAX_LPS = 6;
    localparam int unsigned SCROLL_GAP_CYC = (CLK_HZ + SCROLL_MAX_LPS - 1) / SCROLL_MAX_LPS;
endpackage

// ==== tsi_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module tsi_host (
    input  wire logic       CLK,
    input  wire logic       slow,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    output logic            tx_ready
);
    byte unsigned tq[$];
    byte unsigned rq[$];
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'h0;
        tx_ready = 1'h1;
    end
    always @(posedge CLK) begin
        if (rx_valid && rx_ready)
            void'(tq.pop_front());
        rx_valid <= tq.size() > 0;
        // an idle line shows the inverse, so a stale byte cannot pass
        rx_data <= tq.size() > 0 ? tq[0] : ~rx_data;
        tx_ready <= slow ? ~tx_ready : 1'h1;
        if (tx_valid && tx_ready)
            rq.push_back(tx_data);
    end
endmodule
`default_nettype wire

// ==== tb_terminal_sequence_interpreter.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_terminal_sequence_interpreter;
    logic        clk = 1'h0, rst_n = 1'h0, rx_valid, rx_ready, tx_valid, tx_ready, slow = 1'h0;
    logic        origin = 1'h0, cload, lfull, smooth, inverse, sreq = 1'h0, sgo, nline = 1'h0;
    logic        wreset, ego, tstart, sreset, malf = 1'h0, eight = 1'h0, sexit = 1'h0;
    logic [7:0]  rx_data, tx_data;
    logic [4:0]  row = 5'h01, lrow, top, bot, nrow = 5'h01, wfirst, wlast;
    logic [6:0]  col = 7'h01, lcol;
    logic [3:0]  attr = 4'h0, lattr, tsel, xspd = 4'hf, rspd = 4'h2, flags = 4'h9;
    logic [2:0]  cset = 3'h0, lcset;
    logic [1:0]  emode, par = 2'h1;
    logic [31:0] ev_ld, ev_er, ev_wd, ev_ts;
    int          n_fail = 0, n_tests = 0;
    initial forever #4 clk = ~clk;
    tsi_interp #(.SCROLL_GAP(20)) i_tsi_interp (
        .CLK(clk), .RST_N(rst_n), .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_READY(rx_ready),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready), .CUR_ROW(row),
        .CUR_COL(col), .CUR_ATTR(attr), .CUR_CSET(cset), .MARGIN_ORIGIN_MODE(origin),
        .CURSOR_LOAD(cload), .LOAD_FULL(lfull), .LOAD_ROW(lrow), .LOAD_COL(lcol),
        .LOAD_ATTR(lattr), .LOAD_CSET(lcset), .SMOOTH_SCROLL_MODE(smooth),
        .INVERSE_SCREEN_MODE(inverse), .TOP_MARGIN(top), .BOTTOM_MARGIN(bot), .SCROLL_REQ(sreq),
        .SCROLL_GO(sgo), .NEW_LINE(nline), .NEW_LINE_ROW(nrow), .WIDTH_RESET(wreset),
        .WIDTH_FIRST(wfirst), .WIDTH_LAST(wlast), .ERASE_GO(ego), .ERASE_MODE(emode),
        .TEST_START(tstart), .TEST_SEL(tsel), .SELF_RESET(sreset), .MALFUNCTION(malf),
        .PARITY_SEL(par), .EIGHT_BITS(eight), .TX_SPEED(xspd), .RX_SPEED(rspd),
        .PROCESSOR_OPTION_FLAGS(flags), .SETUP_EXIT(sexit));
    tsi_host i_tsi_host (.CLK(clk), .slow(slow), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
    // pulses are latched so a scenario can judge them after its reply settles
    always @(posedge clk) begin
        if (cload) ev_ld <= {19'h1, lfull, lrow, lcol};
        if (ego) ev_er <= {30'h1, emode};
        if (wreset) ev_wd <= {22'h1, wfirst, wlast};
        if (tstart || sreset) ev_ts <= sreset ? 32'h100 : {28'h1, tsel};
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // wide enough for the longest concatenated compare, so no field is cut off
    task automatic chk(string nm, logic [127:0] e, logic [127:0] s);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic cmd(string s, string e);
        string g = "";
        int i;
        @(negedge clk);
        {ev_ld, ev_er, ev_wd, ev_ts} = '0;
        foreach (s[k]) i_tsi_host.tq.push_back(s[k]);
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (i > 40 && i_tsi_host.tq.size() == 0 && i_tsi_host.rq.size() >= e.len()) break;
        end
        if (i == 400) begin
            n_fail++;
            finish_test();
        end
        while (i_tsi_host.rq.size() > 0) g = {g, string'(i_tsi_host.rq.pop_front())};
        n_tests++;
        if (g != e) begin
            n_fail++;
            $display("BAD reply exp %s got %s", e.substr(1, e.len() - 1), g);
        end
    endtask
    task automatic ex();
        @(posedge clk) sexit <= 1'h1;
        @(posedge clk) sexit <= 1'h0;
    endtask
    task automatic t_report();
        ex();
        cmd("", "");
        slow <= 1'h1;
        cmd("\033[1x", "\033[3;4;2;120;16;1;9x");
        ex();
        cmd("\033[7x", "");
        cmd("\033[x", "\033[2;4;2;120;16;1;9x");
        ex();
        cmd("", "\033[2;4;2;120;16;1;9x");
        slow <= 1'h0;
    endtask
    task automatic t_status();
        cmd("\033[5n", "\033[0n");
        @(posedge clk) malf <= 1'h1;
        cmd("\033[5n", "\033[3n");
        @(posedge clk) {malf, row, col} <= {1'h0, 5'h0c, 7'h22};
        cmd("\033[6n", "\033[12;34R");
    endtask
    task automatic t_modes(string m, logic [1:0] e, int n);
        int c = 0;
        cmd(m, "");
        chk("modes", e, {smooth, inverse});
        @(posedge clk) sreq <= 1'h1;
        repeat (10) @(posedge clk) c += sgo;
        sreq <= 1'h0;
        chk("scroll", n, c);
    endtask
    task automatic t_margins();
        @(posedge clk) origin <= 1'h1;
        cmd("\033[5;10r", "");
        chk("margins", {5'h05, 5'h0a}, {top, bot});
        chk("home", {19'h1, 1'h0, 5'h05, 7'h01}, ev_ld);
        cmd("\033[10;5r", "");
        chk("bad margins", {5'h05, 5'h0a, 32'h0}, {top, bot, ev_ld});
        cmd("\033[r", "");
        chk("default margins", {5'h01, 5'h18}, {top, bot});
        chk("home2", {19'h1, 1'h0, 5'h01, 7'h01}, ev_ld);
        @(posedge clk) origin <= 1'h0;
        cmd("\033[3;9r", "");
        chk("home3", {5'h03, 5'h09, 19'h1, 1'h0, 5'h01, 7'h01}, {top, bot, ev_ld});
    endtask
    task automatic t_cursor_width();
        @(posedge clk) {row, col, attr, cset} <= {5'h03, 7'h09, 4'h5, 3'h2};
        cmd("\0337", "");
        @(posedge clk) {row, col, attr, cset} <= {5'h07, 7'h04, 4'h0, 3'h0};
        cmd("\0338", "");
        chk("restore", {19'h1, 1'h1, 5'h03, 7'h09, 4'h5, 3'h2}, {ev_ld, lattr, lcset});
        cmd("\033#5", "");
        chk("single width", {22'h1, 5'h07, 5'h07, 32'h0}, {ev_wd, ev_ld});
        @(posedge clk) {nline, nrow} <= {1'h1, 5'h0b};
        @(posedge clk) nline <= 1'h0;
        repeat (2) @(posedge clk);
        chk("new line", {22'h1, 5'h0b, 5'h0b}, ev_wd);
        @(posedge clk) {row, col} <= {5'h0a, 7'h05};
        cmd("\033[J", "");
        chk("erase 0", {32'h4, 22'h1, 5'h0b, 5'h18}, {ev_er, ev_wd});
        cmd("\033[1J", "");
        chk("erase 1", {32'h5, 22'h1, 5'h01, 5'h09}, {ev_er, ev_wd});
        cmd("\033[2J", "");
        chk("erase 2", {32'h6, 22'h1, 5'h01, 5'h18, 32'h0}, {ev_er, ev_wd, ev_ld});
    endtask
    task automatic t_test();
        logic [3:0] sel [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
        foreach (sel[k]) begin
            cmd($sformatf("\033[2;%0dy", sel[k]), "");
            chk("test", {28'h1, sel[k]}, ev_ts);
        end
        cmd("\033[3;1y", "");
        chk("bad test", 32'h0, ev_ts);
        cmd("\033[2;0y", "");
        chk("self reset", 32'h100, ev_ts);
        chk("reset margins", {5'h01, 5'h18}, {top, bot});
        ex();
        cmd("", "");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'h1;
        t_report();
        t_status();
        t_modes("\033[?5h\033[4h", 2'h1, 10);
        t_modes("\033[?4h\033[?7h", 2'h3, 1);
        t_modes("\033[?4;5l", 2'h0, 10);
        t_margins();
        t_cursor_width();
        t_test();
        finish_test();
    end
endmodule
`default_nettype wire
